// ==== adcsp_defs.vh ====
/*
 * Shared constants of the converter serial-port sequencer: clock rate,
 * conversion period, turnaround counts, instruction fields and the
 * internal register addresses the sequencer decodes.
 * Assumes the including file runs on the 50 MHz master clock.
 */
`ifndef ADCSP_DEFS_VH
`define ADCSP_DEFS_VH

// master clock and default conversion rate
`define ADCSP_CLK_HZ 50000000
`define ADCSP_CONV_RATE_HZ 814
`define ADCSP_PERIOD_CYC 16'hEFF1

// counts before the period wrap at which the result is refreshed; ready falls 3 cycles after the refresh
`define ADCSP_REFRESH_LEAD 4'h4
// host must finish this many cycles before the next ready fall
`define ADCSP_HOST_MARGIN_CYC 16'h000C

// turnaround counts (cycles of the master clock)
`define ADCSP_SLAVE_TURN_CYC 3'h1
`define ADCSP_MASTER_TURN_CYC 3'h5
`define ADCSP_SLAVE_DONE_CYC 3'h1
`define ADCSP_MASTER_DONE_CYC 3'h3

// instruction byte fields
`define ADCSP_INSTR_RW_BIT 7
`define ADCSP_INSTR_CNT_HI 6
`define ADCSP_INSTR_CNT_LO 5
`define ADCSP_INSTR_ADDR_HI 3
`define ADCSP_INSTR_ADDR_LO 0
`define ADCSP_INSTR_RESET 8'h00

// register addresses decoded by the sequencer
`define ADCSP_RESULT_ADDR_HI 4'h2
`define ADCSP_OFFSET_ADDR_LO 4'h4
`define ADCSP_OFFSET_ADDR_HI 4'h6
`define ADCSP_FSCALE_ADDR_LO 4'h8
`define ADCSP_FSCALE_ADDR_HI 4'hA

// pin synchroniser reset pattern {mode, sync_n, sdio, cs_n, sclk}
`define ADCSP_PIN_RESET 5'h0A

`endif

// ==== adcsp_sync2.v ====
/*
 * Two-flop synchroniser for a group of asynchronous pin inputs.
 * Assumes one clock, synchronous active-low reset; each bit is an
 * independent level, no bus coherence is implied across bits.
 */
`timescale 1ns/100ps
module adcsp_sync2 #(
    parameter W = 5,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // asynchronous levels in, synchronised levels out
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta;
    reg [W-1:0] stable;

    // first stage is read only by the second stage
    always @(posedge core_clk) begin
        if (!rst_n) begin
            meta <= RST_VAL;
            stable <= RST_VAL;
        end else begin
            meta <= d;
            stable <= meta;
        end
    end

    assign q = stable;
endmodule

// ==== adcsp_sequencer.v ====
/*
 * Serial-port sequencer of a delta-sigma converter: conversion period
 * timing, ready output, result refresh, instruction entry and execution
 * in master and slave mode, chip-select handling and continuous read.
 * Assumes the converter core supplies each new result and the register
 * file answers reads combinationally on the same clock.
 */
`timescale 1ns/100ps
`include "adcsp_defs.vh"

// Operation
// - sync low pulse restarts conversion timing, aligning converters on one clock
// - asynchronous sync release aligns converters only to one clock cycle
// - each instruction does one register read or write; first while ready low
// - several instructions per period in slave mode only; master allows one
// - ready stays high during second and later instructions of a period
// - refresh result before ready falls; overlapping offset/scale write marks it invalid
// - a result read in progress blocks refresh; new result discarded
// - outputs float except while transmitting; chip select high never cuts transmission
// - master mode: chip select high holds off communication
// - slave mode: communicate only while chip select is low
// - chip select held low after result read reuses instruction each period
// - first chip select high enables continuous read forever
// - after reset the bidirectional line is the serial data output
// - master with chip select low clocks an instruction every ready-low period
// - an all-ones instruction reads, driving the line for 32 clocks
// - an all-zeros instruction writes one byte to the result, no effect
// - default period gives results at 814Hz, about 1.2ms
// - mode high: master, serial clock out at half the master clock
// - mode low: slave, host clock at most master clock over five
// - ready forced high before refresh, low again once refresh done; the sequencer raises it on the same clock edge as the refresh
// - slave turnaround to output three to four clocks after last instruction edge; the sequencer takes four to five
module adcsp_sequencer #(
    parameter [15:0] PERIOD_CYC = `ADCSP_PERIOD_CYC,
    parameter [3:0] REFRESH_LEAD = `ADCSP_REFRESH_LEAD
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // mode and control pins
    input wire mode_master,
    input wire sync_request_n,
    input wire cs_n,
    // serial clock pin
    input wire sclk_in,
    output wire sclk_out,
    output wire sclk_oe_n,
    // bidirectional data pin and separate data output
    input wire sdio_in,
    output wire sdio_out,
    output wire sdio_oe_n,
    output wire serial_out_line,
    output wire serial_out_oe_n,
    // ready output
    output reg result_ready_n,
    // converter core side
    input wire [23:0] new_result,
    input wire cmd_serial_out_line_sel,
    output reg refresh_strobe,
    output reg modulator_restart,
    output reg result_invalid,
    output reg late_finish,
    // register file side
    output reg [3:0] rd_addr,
    input wire [7:0] rd_data,
    output reg wr_en,
    output reg [3:0] wr_addr,
    output reg [7:0] wr_data
);
    localparam S_IDLE = 5'h01;
    localparam S_INSTR = 5'h02;
    localparam S_TURN = 5'h04;
    localparam S_DATA = 5'h08;
    localparam S_DONE = 5'h10;

    wire [4:0] pins_q;
    wire sclk_s;
    wire cs_s;
    wire sdio_s;
    wire sync_s;
    wire mode_s;
    reg sclk_d;
    reg sync_d;
    reg [4:0] state;
    reg [15:0] pcnt;
    reg [5:0] bitcnt;
    reg [5:0] scnt;
    reg [2:0] gap;
    reg [7:0] instr;
    reg [7:0] rx;
    reg [7:0] tx;
    reg [23:0] conversion_result_reg;
    reg msclk;
    reg [1:0] fall_dly;
    reg reuse;
    reg done_flag;
    reg cont_enabled;
    reg cont_active;
    reg overlap;

    // all pins cross into the master clock domain here
    adcsp_sync2 #(
        .W(5),
        .RST_VAL(`ADCSP_PIN_RESET)
    ) u_pins (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .d({mode_master, sync_request_n, sdio_in, cs_n, sclk_in}),
        .q(pins_q)
    );
    assign sclk_s = pins_q[0];
    assign cs_s = pins_q[1];
    assign sdio_s = pins_q[2];
    assign sync_s = pins_q[3];
    assign mode_s = pins_q[4];

    // decoded fields of the active instruction
    wire is_read = instr[`ADCSP_INSTR_RW_BIT];
    wire [3:0] instr_addr = instr[`ADCSP_INSTR_ADDR_HI:`ADCSP_INSTR_ADDR_LO];
    wire hits_result = (instr_addr <= `ADCSP_RESULT_ADDR_HI);
    wire [2:0] byte_cnt = {1'b0, instr[`ADCSP_INSTR_CNT_HI:`ADCSP_INSTR_CNT_LO]} + 3'h1;
    wire [5:0] data_bits = {byte_cnt, 3'h0};
    wire in_data = (state == S_DATA);
    wire out_active = in_data && is_read;
    wire rd_result_busy = is_read && hits_result && (state == S_TURN || in_data || state == S_DONE);

    // period events
    wire period_end = (pcnt == PERIOD_CYC - 16'h0001);
    wire refresh_at = (pcnt == PERIOD_CYC - {12'h000, REFRESH_LEAD});
    wire in_window = (pcnt >= PERIOD_CYC - {12'h000, REFRESH_LEAD});
    wire sync_rise = sync_s && !sync_d;

    // serial clock events; slave edges count only with chip select low or while data goes out
    // host clock is at most a fifth of core_clk, so the synchroniser misses no edge
    wire s_fall_raw = !mode_s && !sclk_s && sclk_d;
    wire s_fall = s_fall_raw && (!cs_s || out_active);
    wire [5:0] phase_bits = in_data ? data_bits : 6'h08;
    wire m_run = mode_s && (state == S_INSTR || in_data) && (bitcnt < phase_bits);
    wire m_fall = m_run && msclk;
    wire ev_fall = mode_s ? m_fall : s_fall;
    // master samples two cycles late to match the synchroniser delay
    wire sample_ev = mode_s ? fall_dly[1] : s_fall;
    wire last_fall = ev_fall && (bitcnt == phase_bits - 6'h01);

    // byte fetched for transmission: result bytes or the register file
    reg [7:0] read_byte;
    always @* begin
        read_byte = rd_data;
        if (rd_addr <= `ADCSP_RESULT_ADDR_HI) begin
            case (rd_addr[1:0])
                2'h0: read_byte = conversion_result_reg[23:16];
                2'h1: read_byte = conversion_result_reg[15:8];
                default: read_byte = conversion_result_reg[7:0];
            endcase
        end
    end

    // pin drivers; reset value of the select keeps data on the shared line
    assign sclk_out = msclk;
    assign sclk_oe_n = !mode_s;
    assign sdio_out = tx[7];
    assign sdio_oe_n = !(out_active && !cmd_serial_out_line_sel);
    assign serial_out_line = tx[7];
    assign serial_out_oe_n = !(out_active && cmd_serial_out_line_sel);

    // edge history and master clock generation at half the master clock
    always @(posedge core_clk) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            sync_d <= 1'b1;
            msclk <= 1'b0;
            fall_dly <= 2'h0;
        end else begin
            sclk_d <= sclk_s;
            sync_d <= sync_s;
            fall_dly <= {fall_dly[0], m_fall};
            if (m_run) begin
                msclk <= !msclk;
            end else begin
                msclk <= 1'b0;
            end
        end
    end

    // conversion period, refresh and ready output
    always @(posedge core_clk) begin
        if (!rst_n) begin
            pcnt <= 16'h0000;
            result_ready_n <= 1'b1;
            refresh_strobe <= 1'b0;
            modulator_restart <= 1'b0;
            conversion_result_reg <= 24'h000000;
            result_invalid <= 1'b0;
            overlap <= 1'b0;
        end else begin
            refresh_strobe <= 1'b0;
            modulator_restart <= 1'b0;
            // restart lands on the first clock edge seeing the release
            if (sync_rise) begin
                pcnt <= 16'h0000;
                modulator_restart <= 1'b1;
            end else if (period_end) begin
                pcnt <= 16'h0000;
            end else begin
                pcnt <= pcnt + 16'h0001;
            end
            if (refresh_at) begin
                result_ready_n <= 1'b1;
                if (!rd_result_busy) begin
                    conversion_result_reg <= new_result;
                    refresh_strobe <= 1'b1;
                    result_invalid <= overlap;
                end
            end else if (period_end && !sync_rise) begin
                result_ready_n <= 1'b0;
            end else if (state == S_DONE && gap == 3'h0) begin
                result_ready_n <= 1'b1;
            end
            // a blocked refresh leaves the old result untouched
            if (refresh_at && rd_result_busy) begin
                overlap <= overlap;
            end else if (wr_en && in_window && ((wr_addr >= `ADCSP_OFFSET_ADDR_LO &&
                     wr_addr <= `ADCSP_OFFSET_ADDR_HI) || (wr_addr >= `ADCSP_FSCALE_ADDR_LO &&
                     wr_addr <= `ADCSP_FSCALE_ADDR_HI))) begin
                overlap <= 1'b1;
            end else if (refresh_at) begin
                overlap <= 1'b0;
            end
        end
    end

    // continuous read enable and entry
    always @(posedge core_clk) begin
        if (!rst_n) begin
            cont_enabled <= 1'b0;
            cont_active <= 1'b0;
        end else begin
            if (cs_s) begin
                cont_enabled <= 1'b1;
            end
            if (cs_s) begin
                cont_active <= 1'b0;
            end else if (state == S_DONE && gap == 3'h0 && is_read && hits_result && cont_enabled) begin
                cont_active <= 1'b1;
            end
        end
    end

    // receive shift register runs in every active phase
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rx <= 8'h00;
        end else if (state != S_IDLE && sample_ev) begin
            rx <= {rx[6:0], sdio_s};
        end
    end

    // instruction sequencer
    always @(posedge core_clk) begin
        if (!rst_n) begin
            state <= S_IDLE;
            bitcnt <= 6'h00;
            scnt <= 6'h00;
            gap <= 3'h0;
            instr <= `ADCSP_INSTR_RESET;
            tx <= 8'h00;
            rd_addr <= 4'h0;
            wr_en <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 8'h00;
            reuse <= 1'b0;
            done_flag <= 1'b0;
            late_finish <= 1'b0;
        end else begin
            wr_en <= 1'b0;
            late_finish <= 1'b0;
            if (period_end) begin
                done_flag <= 1'b0;
            end
            // data-phase writes, one strobe per completed byte
            if ((in_data || state == S_DONE) && !is_read && sample_ev) begin
                scnt <= scnt + 6'h01;
                if (scnt[2:0] == 3'h7) begin
                    wr_data <= {rx[6:0], sdio_s};
                    wr_addr <= instr_addr + {1'b0, scnt[5:3]};
                    // result register ignores writes; all-zero instruction is a no-op
                    wr_en <= !hits_result;
                end
            end
            case (state)
                S_IDLE: begin
                    bitcnt <= 6'h00;
                    if (mode_s) begin
                        // one instruction per period, only with chip select low
                        if (!result_ready_n && !cs_s && !done_flag) begin
                            state <= cont_active ? S_TURN : S_INSTR;
                            reuse <= cont_active;
                            gap <= `ADCSP_MASTER_TURN_CYC;
                        end
                    end else if (!cs_s) begin
                        state <= S_INSTR;
                        reuse <= 1'b0;
                    end
                end
                S_INSTR: begin
                    if (!mode_s && cs_s) begin
                        state <= S_IDLE;
                    end else if (!mode_s && period_end && cont_active && bitcnt == 6'h00) begin
                        state <= S_TURN;
                        reuse <= 1'b1;
                        gap <= `ADCSP_SLAVE_TURN_CYC;
                    end else if (last_fall) begin
                        state <= S_TURN;
                        gap <= mode_s ? `ADCSP_MASTER_TURN_CYC : `ADCSP_SLAVE_TURN_CYC;
                    end else if (ev_fall) begin
                        bitcnt <= bitcnt + 6'h01;
                    end
                end
                S_TURN: begin
                    if (gap == 3'h1) begin
                        // decode one cycle early so the first byte is fetched in time
                        if (!reuse) begin
                            instr <= rx;
                            rd_addr <= rx[`ADCSP_INSTR_ADDR_HI:`ADCSP_INSTR_ADDR_LO];
                        end else begin
                            rd_addr <= instr_addr;
                        end
                        gap <= 3'h0;
                    end else if (gap == 3'h0) begin
                        state <= S_DATA;
                        bitcnt <= 6'h00;
                        scnt <= 6'h00;
                        tx <= read_byte;
                        rd_addr <= rd_addr + 4'h1;
                    end else begin
                        gap <= gap - 3'h1;
                    end
                end
                S_DATA: begin
                    if (!mode_s && cs_s && !is_read) begin
                        state <= S_IDLE;
                    end else if (last_fall) begin
                        // outgoing transfer runs to the end whatever chip select does
                        state <= S_DONE;
                        gap <= mode_s ? `ADCSP_MASTER_DONE_CYC : `ADCSP_SLAVE_DONE_CYC;
                    end else if (ev_fall) begin
                        bitcnt <= bitcnt + 6'h01;
                        if (bitcnt[2:0] == 3'h7) begin
                            tx <= read_byte;
                            rd_addr <= rd_addr + 4'h1;
                        end else begin
                            tx <= {tx[6:0], 1'b0};
                        end
                    end
                end
                S_DONE: begin
                    if (gap == 3'h0) begin
                        state <= S_IDLE;
                        done_flag <= 1'b1;
                        // flags a host that finished too close to the next ready fall
                        late_finish <= (pcnt >= PERIOD_CYC - `ADCSP_HOST_MARGIN_CYC);
                    end else begin
                        gap <= gap - 3'h1;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ==== adcsp_seq_asserts.sv ====
/*
 * Concurrent checks on the sequencer ports: refresh and ready timing,
 * sync restart, serial clock and data line ownership, write gating.
 * Assumes one clock domain, synchronous active-low reset.
 */
`timescale 1ns/100ps
module adcsp_seq_asserts #(
    parameter [15:0] PERIOD_CYC = 16'h03E8,
    parameter [3:0] REFRESH_LEAD = 4'h4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // pins
    input wire logic mode_master,
    input wire logic sync_request_n,
    input wire logic cs_n,
    input wire logic sclk_out,
    input wire logic sclk_oe_n,
    input wire logic sdio_oe_n,
    input wire logic serial_out_oe_n,
    input wire logic result_ready_n,
    // core and register side
    input wire logic cmd_serial_out_line_sel,
    input wire logic refresh_strobe,
    input wire logic modulator_restart,
    input wire logic wr_en,
    input wire logic [3:0] wr_addr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ready is already high when the result is refreshed, low again soon after
    chk_refresh_ready_high: assert property (refresh_strobe |-> result_ready_n)
        else $error("ready low at refresh");
    chk_ready_falls_after: assert property (refresh_strobe |-> ##[1:5] $fell(result_ready_n))
        else $error("ready did not fall after refresh");
    // data goes out on one line only, chosen by the command bit
    chk_sdio_out_select: assert property (!sdio_oe_n |-> !cmd_serial_out_line_sel && serial_out_oe_n)
        else $error("data line enabled against the command bit");
    // mode pin passes two flops before it owns the clock pin
    chk_master_drives_sclk: assert property (mode_master [*4] |-> !sclk_oe_n)
        else $error("master not driving serial clock");
    chk_slave_frees_sclk: assert property (!mode_master [*4] |-> sclk_oe_n)
        else $error("slave driving serial clock");
    chk_sclk_half_rate: assert property ($rose(sclk_out) |=> $fell(sclk_out))
        else $error("serial clock high longer than one cycle");
    // sync release acts only after the synchroniser
    chk_restart_after_sync: assert property ($rose(sync_request_n) |-> ##[2:4] modulator_restart)
        else $error("no restart after sync release");
    chk_restart_one_cycle: assert property (modulator_restart |=> !modulator_restart)
        else $error("restart longer than one cycle");
    chk_no_result_write: assert property (wr_en |-> wr_addr > 4'h2)
        else $error("write reached result address");
    chk_slave_cs_gate: assert property ((!mode_master && cs_n) [*8] |-> !wr_en)
        else $error("write with chip select high");

    cover property (refresh_strobe);
    cover property (modulator_restart);
    cover property (!sdio_oe_n && mode_master);
    cover property (wr_en);
endmodule

bind adcsp_sequencer adcsp_seq_asserts #(.PERIOD_CYC(PERIOD_CYC), .REFRESH_LEAD(REFRESH_LEAD)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .mode_master(mode_master), .sync_request_n(sync_request_n),
    .cs_n(cs_n), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .sdio_oe_n(sdio_oe_n),
    .serial_out_oe_n(serial_out_oe_n), .result_ready_n(result_ready_n), .cmd_serial_out_line_sel(cmd_serial_out_line_sel),
    .refresh_strobe(refresh_strobe), .modulator_restart(modulator_restart), .wr_en(wr_en), .wr_addr(wr_addr));

// ==== adcsp_host.sv ====
/*
 * Host serial port model: chip select, slave-mode clocking and the
 * shared data line with its pull. Assumes the 50 MHz core_clk.
 */
`timescale 1ns/100ps
module adcsp_host (
    // clock
    input wire logic core_clk,
    // sequencer pin drivers
    input wire logic sclk_out,
    input wire logic sclk_oe_n,
    input wire logic sdio_out,
    input wire logic sdio_oe_n,
    // resolved pins
    output wire logic sclk_line,
    output wire logic sdio_line,
    output logic cs_n
);
    logic host_sclk = 1'b0;
    logic host_drv = 1'b0;
    logic host_bit = 1'b0;
    logic pull_level = 1'b0;
    initial cs_n = 1'b1;

    // whoever enables drives; a released data line sits at its pull
    assign sclk_line = !sclk_oe_n ? sclk_out : host_sclk;
    assign sdio_line = !sdio_oe_n ? sdio_out : (host_drv ? host_bit : pull_level);

    // chip select and pull change just after an edge
    task automatic set_pins(input logic cs, input logic pull);
        @(posedge core_clk);
        cs_n <= cs;
        pull_level <= pull;
    endtask

    // one byte msb first; 4+3 cycle clock stays under a fifth of core_clk
    task automatic slave_byte(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge core_clk);
            host_drv <= drv;
            host_bit <= tx[i];
            repeat (3) @(posedge core_clk);
            host_sclk <= 1'b1;
            repeat (3) @(posedge core_clk);
            rx[i] = sdio_line;
            host_sclk <= 1'b0;
        end
        @(posedge core_clk);
        host_drv <= 1'b0;
    endtask
endmodule

// ==== adcsp_sequencer_bench.sv ====
/*
 * Self-checking bench: reset state, period, slave writes and reads,
 * continuous read, sync restart and master transfers.
 * Assumes the host model and checker files compile before it.
 */
`timescale 1ns/100ps
module adcsp_sequencer_bench;
    localparam int P = 1000;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic mode_master = 1'b0;
    logic sync_request_n = 1'b1;
    logic [23:0] new_result = 24'h5A3C96;
    logic cmd_serial_out_line_sel = 1'b0;
    wire [7:0] rd_data;
    wire [3:0] rd_addr, wr_addr;
    wire [7:0] wr_data;
    wire sclk_out, sclk_oe_n, sdio_out, sdio_oe_n, serial_out_line, serial_out_oe_n, result_ready_n;
    wire refresh_strobe, modulator_restart, result_invalid, late_finish, wr_en, sclk_line, sdio_line, cs_n;
    int n_errors = 0;
    int checks = 0;
    int n_wr = 0;
    int n_rise = 0;
    int n_clk = 0;
    int n, m, k;
    logic sclk_q = 1'b0;
    logic [3:0] wr_a = 4'h0;
    logic [7:0] wr_d = 8'h00;
    logic [7:0] rx;
    logic [23:0] v;

    always #10 core_clk = ~core_clk;
    // register file stand-in answers with its own address
    assign rd_data = {4'hC, rd_addr};

    adcsp_sequencer #(.PERIOD_CYC(16'h03E8), .REFRESH_LEAD(4'h4)) u_adcsp_sequencer (
        .core_clk(core_clk), .rst_n(rst_n), .mode_master(mode_master), .sync_request_n(sync_request_n),
        .cs_n(cs_n), .sclk_in(sclk_line), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .sdio_in(sdio_line),
        .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .serial_out_line(serial_out_line),
        .serial_out_oe_n(serial_out_oe_n), .result_ready_n(result_ready_n), .new_result(new_result),
        .cmd_serial_out_line_sel(cmd_serial_out_line_sel), .refresh_strobe(refresh_strobe), .modulator_restart(modulator_restart),
        .result_invalid(result_invalid), .late_finish(late_finish), .rd_addr(rd_addr), .rd_data(rd_data),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
    adcsp_host u_adcsp_host (.core_clk(core_clk), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
        .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .sclk_line(sclk_line), .sdio_line(sdio_line), .cs_n(cs_n));

    // record writes and serial clock rises; counters only grow, scenarios take differences
    always @(posedge core_clk) begin
        sclk_q <= sclk_out;
        if (wr_en === 1'b1) begin
            n_wr <= n_wr + 1;
            wr_a <= wr_addr;
            wr_d <= wr_data;
        end
        if (sclk_out === 1'b1 && sclk_q === 1'b0) begin
            n_clk <= n_clk + 1;
            if (sdio_oe_n === 1'b0)
                n_rise <= n_rise + 1;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ready high then low, bounded so a stuck ready ends the run
    task automatic wait_fall;
        k = 0;
        while (result_ready_n !== 1'b1 && k < 3 * P) begin
            @(posedge core_clk);
            k++;
        end
        while (result_ready_n !== 1'b0 && k < 3 * P) begin
            @(posedge core_clk);
            k++;
        end
        if (k >= 3 * P) begin
            n_errors++;
            print_verdict;
        end
    endtask

    // instruction byte, turnaround, one data byte, then gap before the next
    task automatic slave_write(input logic [7:0] ins, input logic [7:0] dat);
        u_adcsp_host.slave_byte(ins, 1'b1, rx);
        repeat (8) @(posedge core_clk);
        u_adcsp_host.slave_byte(dat, 1'b1, rx);
        repeat (24) @(posedge core_clk);
    endtask

    // three result bytes, chip select optionally lifted after the first
    task automatic read_bytes(input logic lift);
        u_adcsp_host.slave_byte(8'h00, 1'b0, v[23:16]);
        if (lift)
            u_adcsp_host.set_pins(1'b1, 1'b0);
        u_adcsp_host.slave_byte(8'h00, 1'b0, v[15:8]);
        u_adcsp_host.slave_byte(8'h00, 1'b0, v[7:0]);
    endtask

    task automatic s_reset;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        check({sdio_oe_n, serial_out_oe_n, result_ready_n}, 3'h7);
    endtask

    task automatic s_period;
        wait_fall;
        n = $time / 20;
        wait_fall;
        check(32'($time / 20 - n), P);
    endtask

    // three writes in one period, all done well before the next fall
    task automatic s_slave_writes;
        wait_fall;
        u_adcsp_host.set_pins(1'b0, 1'b0);
        slave_write(8'h04, 8'hA5);
        check({wr_a, wr_d}, 12'h4A5);
        check(result_ready_n, 1'b1);
        slave_write(8'h08, 8'h3C);
        check({wr_a, wr_d}, 12'h83C);
        check(result_ready_n, 1'b1);
        n = n_wr;
        slave_write(8'h00, 8'hFF);
        check(n_wr - n, 0);
        check(result_invalid, 1'b0);
        u_adcsp_host.set_pins(1'b1, 1'b0);
    endtask
    task automatic s_slave_read;
        wait_fall;
        u_adcsp_host.set_pins(1'b0, 1'b0);
        u_adcsp_host.slave_byte(8'hC0, 1'b1, rx);
        repeat (8) @(posedge core_clk);
        read_bytes(1'b1);
        check(v, 24'h5A3C96);
    endtask

    // read with chip select kept low, then the next result comes unasked
    task automatic s_cont_read;
        new_result <= 24'h1E2D4B;
        wait_fall;
        u_adcsp_host.set_pins(1'b0, 1'b0);
        u_adcsp_host.slave_byte(8'hC0, 1'b1, rx);
        repeat (8) @(posedge core_clk);
        read_bytes(1'b0);
        check(v, 24'h1E2D4B);
        new_result <= 24'h0F0A55;
        wait_fall;
        repeat (8) @(posedge core_clk);
        read_bytes(1'b0);
        check(v, 24'h0F0A55);
        u_adcsp_host.set_pins(1'b1, 1'b0);
    endtask

    task automatic s_sync;
        @(posedge core_clk);
        sync_request_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        sync_request_n <= 1'b1;
        k = 0;
        while (modulator_restart !== 1'b1 && k < 8) begin
            @(posedge core_clk);
            k++;
        end
        check(k < 8, 1'b1);
        k = 0;
        while (refresh_strobe !== 1'b1 && k < 2 * P) begin
            @(posedge core_clk);
            k++;
        end
        check(k >= P - 5 && k <= P - 1, 1'b1);
    endtask

    // master: line high reads 32 bits, line low writes nothing, chip select high holds off
    task automatic s_master;
        mode_master <= 1'b1;
        u_adcsp_host.set_pins(1'b0, 1'b1);
        wait_fall;
        wait_fall;
        n = n_rise;
        m = n_clk;
        wait_fall;
        check(n_rise - n, 32);
        check(n_clk - m, 40);
        u_adcsp_host.set_pins(1'b0, 1'b0);
        wait_fall;
        n = n_rise;
        m = n_wr;
        wait_fall;
        check(n_rise - n, 0);
        check(n_wr - m, 0);
        u_adcsp_host.set_pins(1'b1, 1'b0);
        wait_fall;
        n = n_clk;
        wait_fall;
        check(n_clk - n, 0);
    endtask

    initial begin
        s_reset;
        s_period;
        s_slave_writes;
        s_slave_read;
        s_cont_read;
        s_sync;
        s_master;
        print_verdict;
    end
endmodule
